// ==== hdl/adc_cvd_control.sv ====
// Functional notes
// - precharge polarity drives pin high and hold cap low; ignored at zero precharge time
// - double sample with inversion enabled flips second-cycle precharge and guard polarities
// - guard outputs start at guard polarity level during precharge
// - sample-cap-only bit keeps precharge off the external pin
// - double sample pairs conversions; computation after every second one
// - conversion start copies filter or result into previous value
// - low-pass mode time constant is two to the shift field
// - accumulate and average modes right-shift accumulated value by shift field
// - shift field ignored in basic mode and reserved code seven
// - clear command zeroes accumulator, counter, overflow; hardware clears the bit
// - mode field selects basic, accumulate, average, burst, low-pass
// - error select chooses difference; reserved codes give zero
// - double sample uses result minus previous in place of result
// - guard A inverts at acquisition, B holds; A toggles again second time
// - double sample with result source computes error every second sample
//
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "adc_cvd_defines.svh"

module adc_cvd_control (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [17:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        CONV_START,
    input  wire logic        CONV_DONE,
    input  wire logic [9:0]  CONV_RESULT,
    input  wire logic        STAGE_PRECHARGE,
    input  wire logic        STAGE_ACQUIRE,
    input  wire logic        SECOND_CYCLE,
    output logic             GUARD_A,
    output logic             GUARD_B,
    output logic             PIN_DRIVE_EN,
    output logic             PIN_DRIVE_HIGH,
    output logic             HOLD_CHARGE_HIGH,
    output logic             IRQ
);
    compute_if cif ();

    logic [7:0]                pre_ctrl_q;
    logic [7:0]                cmp_ctrl_q;
    logic [7:0]                err_ctrl_q;
    logic [7:0]                pre_time_q;
    logic signed [15:0]        setpoint_q;
    logic [`IRQ_BITS-1:0]      irq_stat_q;
    logic [`IRQ_BITS-1:0]      irq_mask_q;
    logic                      ovf_seen_q;
    adc_cvd_pkg::guard_phase_t gph_q;
    logic                      wr_en;
    logic                      rd_setup;
    logic [15:0]               idx;
    logic                      idx_ok;
    logic [31:0]               rd_word;
    logic                      inv_d;
    logic                      precharge_polarity_d;
    logic                      guard_polarity_d;
    logic [`IRQ_BITS-1:0]      irq_evt;

    // true when the byte address hits the given register index
    function automatic logic hit(input logic [17:0] a, input logic [15:0] i);
        hit = (a[17:2] == i) && (a[1:0] == 2'b00);
    endfunction

    assign idx      = PADDR[17:2];
    assign wr_en    = PSEL && PENABLE && PREADY && PWRITE;
    assign rd_setup = PSEL && !PENABLE;

    // register index decode; unmapped addresses answer with an error
    always_comb begin
        idx_ok  = 1'b1;
        rd_word = 32'h00000000;
        if (hit(PADDR, `IDX_PRECHARGE_CTRL)) begin
            rd_word = {24'h000000, pre_ctrl_q};
        end else if (hit(PADDR, `IDX_COMPUTE_CTRL)) begin
            rd_word = {24'h000000, cmp_ctrl_q};
        end else if (hit(PADDR, `IDX_ERROR_CTRL)) begin
            rd_word = {24'h000000, err_ctrl_q};
        end else if (hit(PADDR, `IDX_IRQ_STATUS)) begin
            rd_word = {29'h0, irq_stat_q};
        end else if (hit(PADDR, `IDX_IRQ_MASK)) begin
            rd_word = {29'h0, irq_mask_q};
        end else if (hit(PADDR, `IDX_PRECHARGE_TIME)) begin
            rd_word = {24'h000000, pre_time_q};
        end else if (hit(PADDR, `IDX_SETPOINT)) begin
            rd_word = {16'h0000, setpoint_q};
        end else if (hit(PADDR, `IDX_ERROR_VALUE)) begin
            rd_word = {16'h0000, cif.error};
        end else if (hit(PADDR, `IDX_PREVIOUS_VALUE)) begin
            rd_word = {16'h0000, cif.previous};
        end else if (hit(PADDR, `IDX_FILTER_OUTPUT)) begin
            rd_word = {16'h0000, cif.filter};
        end else if (hit(PADDR, `IDX_ACCUMULATOR)) begin
            rd_word = {14'h0, cif.accum};
        end else if (hit(PADDR, `IDX_SAMPLE_COUNTER)) begin
            rd_word = {24'h000000, cif.count};
        end else begin
            idx_ok  = 1'b0;
        end
    end

    // apb answer: one access cycle, data and error registered at setup
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= rd_setup;
            PSLVERR <= rd_setup && !idx_ok;
            if (rd_setup && !PWRITE) begin
                PRDATA <= rd_word;
            end
        end
    end

    // plain control registers; reserved bits of precharge control and bit 7 of error control stay zero
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pre_ctrl_q <= `RST_CTRL;
            err_ctrl_q <= `RST_CTRL;
            pre_time_q <= `RST_CTRL;
            setpoint_q <= `RST_WORD16;
            irq_mask_q <= `IRQ_BITS'(0);
        end else if (wr_en) begin
            if (hit(PADDR, `IDX_PRECHARGE_CTRL)) begin
                pre_ctrl_q <= PWDATA[7:0] & `MASK_PRECHARGE_CTRL;
            end else if (hit(PADDR, `IDX_ERROR_CTRL)) begin
                err_ctrl_q <= PWDATA[7:0] & `MASK_ERROR_CTRL;
            end else if (hit(PADDR, `IDX_PRECHARGE_TIME)) begin
                pre_time_q <= PWDATA[7:0];
            end else if (hit(PADDR, `IDX_SETPOINT)) begin
                setpoint_q <= PWDATA[15:0];
            end else if (hit(PADDR, `IDX_IRQ_MASK)) begin
                irq_mask_q <= PWDATA[`IRQ_BITS-1:0];
            end
        end
    end

    // clear command set by software, dropped by hardware on done; a write wins
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cmp_ctrl_q <= `RST_CTRL;
        end else if (wr_en && hit(PADDR, `IDX_COMPUTE_CTRL)) begin
            cmp_ctrl_q <= {PWDATA[7:4], PWDATA[3] | cmp_ctrl_q[3], PWDATA[2:0]};
        end else if (cif.clear_done) begin
            cmp_ctrl_q[`POS_ACCUM_CLEAR] <= 1'b0;
        end
    end

    // feed the compute unit
    // mode field straight from the control register
    assign cif.mode          = cmp_ctrl_q[`MSB_MODE:`LSB_MODE];
    assign cif.shift         = cmp_ctrl_q[`MSB_SHIFT:`LSB_SHIFT];
    assign cif.prev_src      = cmp_ctrl_q[`POS_PREV_SRC];
    assign cif.clear_req     = cmp_ctrl_q[`POS_ACCUM_CLEAR];
    assign cif.error_select_a          = err_ctrl_q[`MSB_ERROR_SELECT_A:`LSB_ERROR_SELECT_A];
    assign cif.double_sample = pre_ctrl_q[`POS_DOUBLE_SAMPLE];
    assign cif.setpoint      = setpoint_q;
    assign cif.conv_start    = CONV_START;
    assign cif.conv_done     = CONV_DONE;
    assign cif.result        = CONV_RESULT;

    adc_compute_unit u_compute (
        .clk     (CLK),
        .reset_n (RESET_N),
        .cu      (cif.unit)
    );

    // second cycle of a pair inverts when enabled
    assign inv_d  = pre_ctrl_q[`POS_DOUBLE_SAMPLE] && pre_ctrl_q[`POS_INV_PRE_EN] && SECOND_CYCLE;
    assign precharge_polarity_d = pre_ctrl_q[`POS_PRECHARGE_POL] ^ inv_d;
    assign guard_polarity_d = pre_ctrl_q[`POS_GUARD_POL] ^ inv_d;

    // guard phase follows the sequencer stages
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            gph_q <= adc_cvd_pkg::GPH_IDLE;
        end else begin
            case (gph_q)
                adc_cvd_pkg::GPH_IDLE:    if (STAGE_PRECHARGE) gph_q <= adc_cvd_pkg::GPH_PRECHG;
                adc_cvd_pkg::GPH_PRECHG:  if (STAGE_ACQUIRE) gph_q <= adc_cvd_pkg::GPH_ACQUIRE;
                adc_cvd_pkg::GPH_ACQUIRE: if (STAGE_PRECHARGE) gph_q <= adc_cvd_pkg::GPH_PRECHG;
                                          else if (!STAGE_ACQUIRE) gph_q <= adc_cvd_pkg::GPH_IDLE;
                default:                  gph_q <= adc_cvd_pkg::GPH_IDLE;
            endcase
        end
    end

    // guard outputs keep their level between stages
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            GUARD_A <= 1'b0;
            GUARD_B <= 1'b0;
        end else if (STAGE_PRECHARGE) begin
            GUARD_A <= guard_polarity_d;
            GUARD_B <= guard_polarity_d;
        end else if (STAGE_ACQUIRE && gph_q == adc_cvd_pkg::GPH_PRECHG) begin
            // A flips on acquisition, B holds
            GUARD_A <= ~GUARD_A;
        end
    end

    // precharge drivers, only while precharge time is nonzero
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            PIN_DRIVE_EN     <= 1'b0;
            PIN_DRIVE_HIGH   <= 1'b0;
            HOLD_CHARGE_HIGH <= 1'b0;
        end else if (STAGE_PRECHARGE && pre_time_q != 8'h00) begin
            // cap-only mode leaves the pin undriven
            PIN_DRIVE_EN     <= !pre_ctrl_q[`POS_CAP_ONLY];
            // pin follows polarity, hold cap opposite
            PIN_DRIVE_HIGH   <= precharge_polarity_d;
            HOLD_CHARGE_HIGH <= !precharge_polarity_d;
        end else begin
            PIN_DRIVE_EN     <= 1'b0;
            PIN_DRIVE_HIGH   <= 1'b0;
            HOLD_CHARGE_HIGH <= 1'b0;
        end
    end

    assign irq_evt = {cif.overflow && !ovf_seen_q, cif.clear_done, cif.compute_done};

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            irq_stat_q <= `IRQ_BITS'(0);
            ovf_seen_q <= 1'b0;
            IRQ        <= 1'b0;
        end else begin
            ovf_seen_q <= cif.overflow;
            if (wr_en && hit(PADDR, `IDX_IRQ_STATUS)) begin
                irq_stat_q <= (irq_stat_q & ~PWDATA[`IRQ_BITS-1:0]) | irq_evt;
            end else begin
                irq_stat_q <= irq_stat_q | irq_evt;
            end
            IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end

    // no pin drive with zero precharge time
    zero_time_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        pre_time_q == 8'h00 |=> !PIN_DRIVE_EN && !HOLD_CHARGE_HIGH)
        else $error("precharge drove with zero precharge time");
    cap_only_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        STAGE_PRECHARGE && pre_ctrl_q[`POS_CAP_ONLY] |=> !PIN_DRIVE_EN)
        else $error("pin driven in cap-only precharge");
    // hold cap opposite to pin during precharge
    hold_opposite_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        PIN_DRIVE_EN |-> HOLD_CHARGE_HIGH == !PIN_DRIVE_HIGH)
        else $error("hold cap not opposite to pin");
    guard_start_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        STAGE_PRECHARGE && !inv_d |=> GUARD_A == $past(pre_ctrl_q[`POS_GUARD_POL]) && GUARD_A == GUARD_B)
        else $error("guard outputs wrong at precharge");
    // A inverts against B on acquisition
    guard_split_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        STAGE_ACQUIRE && gph_q == adc_cvd_pkg::GPH_PRECHG && !STAGE_PRECHARGE |=> GUARD_A != GUARD_B)
        else $error("guard A did not invert on acquisition");
    inv_second_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        STAGE_PRECHARGE && inv_d && pre_time_q != 8'h00 |=> PIN_DRIVE_HIGH != $past(pre_ctrl_q[7]))
        else $error("second cycle precharge not inverted");
    clear_bit_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        cif.clear_done && !wr_en |=> !cmp_ctrl_q[`POS_ACCUM_CLEAR] && cif.accum == 18'h0)
        else $error("clear command or accumulator not cleared");

    cover_double_c: cover property (@(posedge CLK) disable iff (!RESET_N)
        cif.double_sample ##1 cif.compute_done);
    cover_clear_c: cover property (@(posedge CLK) disable iff (!RESET_N) cif.clear_done);
    cover_irq_c: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(IRQ));
endmodule

`default_nettype wire

// ==== hdl/adc_cvd_defines.svh ====
`ifndef ADC_CVD_DEFINES_SVH
`define ADC_CVD_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_PRECHARGE_CTRL  16'h1d27
`define IDX_COMPUTE_CTRL    16'h1d28
`define IDX_ERROR_CTRL      16'h1d29
`define IDX_IRQ_STATUS      16'h1d30
`define IDX_IRQ_MASK        16'h1d31
`define IDX_PRECHARGE_TIME  16'h1d32
`define IDX_SETPOINT        16'h1d33
`define IDX_ERROR_VALUE     16'h1d34
`define IDX_PREVIOUS_VALUE  16'h1d35
`define IDX_FILTER_OUTPUT   16'h1d36
`define IDX_ACCUMULATOR     16'h1d37
`define IDX_SAMPLE_COUNTER  16'h1d38

// precharge control fields
`define POS_PRECHARGE_POL   7
`define POS_INV_PRE_EN      6
`define POS_GUARD_POL       5
`define POS_CAP_ONLY        1
`define POS_DOUBLE_SAMPLE   0
`define MASK_PRECHARGE_CTRL 8'he3

// compute control fields
`define POS_PREV_SRC        7
`define MSB_SHIFT           6
`define LSB_SHIFT           4
`define POS_ACCUM_CLEAR     3
`define MSB_MODE            2
`define LSB_MODE            0

// error control fields
`define MSB_ERROR_SELECT_A            6
`define LSB_ERROR_SELECT_A            4
`define MASK_ERROR_CTRL     8'h7f

// interrupt status bits
`define IRQ_COMPUTE_DONE    0
`define IRQ_CLEAR_DONE      1
`define IRQ_OVERFLOW        2
`define IRQ_BITS            3

// reset values
`define RST_CTRL            8'h00
`define RST_WORD16          16'h0000

// accumulator clear duration
`define CLEAR_CYCLES        4'h4

`endif

// ==== hdl/adc_cvd_pkg.sv ====
package adc_cvd_pkg;

    typedef enum logic [2:0] {
        MODE_BASIC      = 3'h0,
        MODE_ACCUMULATE = 3'h1,
        MODE_AVERAGE    = 3'h2,
        MODE_BURST      = 3'h3,
        MODE_LOWPASS    = 3'h4
    } mode_t;

    typedef enum logic [2:0] {
        ERROR_SELECT_A_RES_PREV  = 3'h0,
        ERROR_SELECT_A_RES_SETPT = 3'h1,
        ERROR_SELECT_A_RES_FILT  = 3'h2,
        ERROR_SELECT_A_PREV_FILT = 3'h4,
        ERROR_SELECT_A_FILT_SETPT = 3'h5
    } error_select_a_t;

    // guard drive phase, one-hot
    typedef enum logic [2:0] {
        GPH_IDLE    = 3'h1,
        GPH_PRECHG  = 3'h2,
        GPH_ACQUIRE = 3'h4
    } guard_phase_t;

endpackage

// ==== hdl/compute_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface compute_if;
    logic               conv_start;
    logic               conv_done;
    logic [9:0]         result;
    logic [2:0]         mode;
    logic [2:0]         shift;
    logic               prev_src;
    logic               double_sample;
    logic [2:0]         error_select_a;
    logic signed [15:0] setpoint;
    logic               clear_req;
    logic               clear_done;
    logic               compute_done;
    logic               overflow;
    logic signed [15:0] previous;
    logic signed [15:0] filter;
    logic signed [17:0] accum;
    logic signed [15:0] error;
    logic [7:0]         count;

    modport ctrl (output conv_start, conv_done, result, mode, shift, prev_src, double_sample, error_select_a,
                  setpoint, clear_req,
                  input  clear_done, compute_done, overflow, previous, filter, accum, error, count);
    modport unit (input  conv_start, conv_done, result, mode, shift, prev_src, double_sample, error_select_a,
                  setpoint, clear_req,
                  output clear_done, compute_done, overflow, previous, filter, accum, error, count);
endinterface

`default_nettype wire

// ==== hdl/adc_compute_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "adc_cvd_defines.svh"

module adc_compute_unit (
    input  wire logic  clk,
    input  wire logic  reset_n,
    compute_if.unit    cu
);
    logic               pair_half_q;
    logic signed [15:0] res_q;
    logic signed [15:0] sample;
    logic signed [17:0] acc_n;
    logic signed [15:0] filt_n;
    logic               ovf_n;
    logic               do_compute;
    logic [3:0]         clr_cnt_q;
    logic               shift_used;

    // arithmetic right shift, also used for the filter decay term
    function automatic logic signed [17:0] shr(input logic signed [17:0] v, input logic [2:0] s);
        shr = v >>> s;
    endfunction

    assign shift_used = (cu.mode != 3'h0) && (cu.mode != 3'h7);
    assign do_compute = cu.conv_done && !(cu.double_sample && !pair_half_q);
    assign sample = cu.double_sample ? $signed({6'h00, cu.result}) - cu.previous
                                     : $signed({6'h00, cu.result});

    // next accumulator and filter value
    always_comb begin
        acc_n  = cu.accum;
        filt_n = cu.filter;
        ovf_n  = 1'b0;
        case (cu.mode)
            adc_cvd_pkg::MODE_ACCUMULATE,
            adc_cvd_pkg::MODE_AVERAGE,
            adc_cvd_pkg::MODE_BURST: begin
                acc_n  = cu.accum + 18'(sample);
                filt_n = 16'(shr(acc_n, cu.shift));
                ovf_n  = (cu.accum[17] == sample[15]) && (acc_n[17] != cu.accum[17]);
            end
            adc_cvd_pkg::MODE_LOWPASS: begin
                // time constant two to the shift
                acc_n  = cu.accum - shr(cu.accum, cu.shift) + 18'(sample);
                filt_n = 16'(shr(acc_n, cu.shift));
                ovf_n  = (cu.accum[17] == sample[15]) && (acc_n[17] != cu.accum[17]);
            end
            // shift ignored in basic and reserved
            default: begin
                acc_n  = cu.accum;
                filt_n = cu.filter;
            end
        endcase
    end

    // pair phase and latest result
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pair_half_q <= 1'b0;
            res_q       <= `RST_WORD16;
        end else if (cu.conv_done) begin
            res_q       <= $signed({6'h00, cu.result});
            pair_half_q <= cu.double_sample && !pair_half_q;
        end
    end

    // previous value taken at conversion start
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cu.previous <= `RST_WORD16;
        end else if (cu.conv_start) begin
            cu.previous <= cu.prev_src ? cu.filter : res_q;
        end
    end

    // clear takes a fixed number of cycles, then reports done
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clr_cnt_q     <= 4'h0;
            cu.clear_done <= 1'b0;
        end else begin
            cu.clear_done <= 1'b0;
            if (!cu.clear_req) begin
                clr_cnt_q <= 4'h0;
            end else if (clr_cnt_q == `CLEAR_CYCLES - 4'h1) begin
                clr_cnt_q     <= 4'h0;
                cu.clear_done <= 1'b1;
            end else if (!cu.clear_done) begin
                clr_cnt_q <= clr_cnt_q + 4'h1;
            end
        end
    end

    // accumulator, counter, filter and overflow
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cu.accum    <= 18'h0;
            cu.count    <= 8'h00;
            cu.filter   <= `RST_WORD16;
            cu.overflow <= 1'b0;
        end else if (cu.clear_done) begin
            cu.accum    <= 18'h0;
            cu.count    <= 8'h00;
            cu.overflow <= 1'b0;
        end else if (do_compute && shift_used) begin
            cu.accum    <= acc_n;
            cu.count    <= cu.count + 8'h01;
            cu.filter   <= filt_n;
            cu.overflow <= cu.overflow | ovf_n;
        end
    end

    // error selection, reserved codes give zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cu.error        <= `RST_WORD16;
            cu.compute_done <= 1'b0;
        end else begin
            cu.compute_done <= do_compute;
            if (do_compute) begin
                case (cu.error_select_a)
                    adc_cvd_pkg::ERROR_SELECT_A_RES_PREV:   cu.error <= $signed({6'h00, cu.result}) - cu.previous;
                    adc_cvd_pkg::ERROR_SELECT_A_RES_SETPT:  cu.error <= sample - cu.setpoint;
                    adc_cvd_pkg::ERROR_SELECT_A_RES_FILT:   cu.error <= sample - filt_n;
                    adc_cvd_pkg::ERROR_SELECT_A_PREV_FILT:  cu.error <= cu.previous - filt_n;
                    adc_cvd_pkg::ERROR_SELECT_A_FILT_SETPT: cu.error <= filt_n - cu.setpoint;
                    default:                      cu.error <= `RST_WORD16;
                endcase
            end
        end
    end

    // single skips nothing, double skips first half
    pair_skip_a: assert property (@(posedge clk) disable iff (!reset_n)
        cu.conv_done && cu.double_sample && !pair_half_q |=> !cu.compute_done)
        else $error("computation ran after first half of pair");
    // clear done follows request within one to six cycles
    clear_time_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(cu.clear_req) |-> ##[1:6] cu.clear_done)
        else $error("accumulator clear did not finish in time");
    prev_src_a: assert property (@(posedge clk) disable iff (!reset_n)
        cu.conv_start && cu.prev_src |=> cu.previous == $past(cu.filter))
        else $error("previous value not taken from filter");
    // basic mode leaves the accumulator alone
    basic_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        cu.mode == 3'h0 && !cu.clear_done |=> cu.accum == $past(cu.accum))
        else $error("accumulator changed in basic mode");
endmodule

`default_nettype wire

// ==== verif/seq_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module seq_model (
    input  wire logic       clk,
    output logic            start,
    output logic            done,
    output logic [9:0]      result,
    output logic            pre,
    output logic            acq,
    output logic            second
);
    initial {start, done, result, pre, acq, second} = '0;

    // one conversion: start pulse together with precharge, then acquire, then done with result
    // result bus shows the inverse outside done so a stale value never matches
    task automatic convert(input logic [9:0] r, input logic sec, input int slow);
        @(posedge clk) {start, pre, second} <= {2'b11, sec};
        @(posedge clk) start <= 1'b0;
        repeat (2 + slow) @(posedge clk);
        {pre, acq} <= 2'b01;
        repeat (4 + slow) @(posedge clk);
        {acq, done, result} <= {2'b01, r};
        @(posedge clk) {done, result} <= {1'b0, ~r};
    endtask
endmodule

`default_nettype wire

// ==== verif/test_adc_cvd_control.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "adc_cvd_defines.svh"

module test_adc_cvd_control;
    logic        CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, slv, inv, g, p;
    logic [17:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic [15:0] spt;
    logic [9:0]  res, a, b, v;
    logic [7:0]  pc;
    logic [2:0]  codes [8] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h2, 3'h4, 3'h5, 3'h7};
    logic        PREADY, PSLVERR, cs, cd, pre, acq, sec, ga, gb, pe, ph, hh, IRQ;
    int          err_count = 0, n_checks = 0, s, n, m;

    always #20 CLK = ~CLK;

    adc_cvd_control u_adc_cvd_control (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CONV_START(cs), .CONV_DONE(cd), .CONV_RESULT(res), .STAGE_PRECHARGE(pre), .STAGE_ACQUIRE(acq),
        .SECOND_CYCLE(sec), .GUARD_A(ga), .GUARD_B(gb), .PIN_DRIVE_EN(pe), .PIN_DRIVE_HIGH(ph),
        .HOLD_CHARGE_HIGH(hh), .IRQ(IRQ));
    seq_model u_seq_model (.clk(CLK), .start(cs), .done(cd), .result(res), .pre(pre), .acq(acq), .second(sec));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // one apb transfer; pready sampled at the edge, a stuck slave ends the run
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge CLK) {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, idx, 2'b00, wd};
        @(posedge CLK) PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1 && ++k < 20);
        {rd, slv} = {PRDATA, PSLVERR};
        {PSEL, PENABLE} <= 2'b00;
        if (k >= 20) begin
            err_count++;
            print_verdict();
        end
    endtask

    function automatic logic [15:0] err_exp(input logic [2:0] c, input logic [15:0] x, y, sp);
        case (c)
            3'h0: return y - x;
            3'h1: return y - sp;
            // filter output still at its reset value in basic mode
            3'h2: return y;
            3'h4: return x;
            3'h5: return 16'h0000 - sp;
            default: return 16'h0000;
        endcase
    endfunction

    initial begin
        void'($urandom(32'hd694eb38));
        repeat (20) @(posedge CLK);
        RESET_N <= 1'b1;
        // reset value and an unmapped index
        apb(0, `IDX_COMPUTE_CTRL, 0);
        check(rd, 0);
        apb(0, 16'h0001, 0);
        check(slv, 1);
        $display("test registers done");
        // guard and precharge drive over both cycles of a pair
        apb(1, `IDX_PRECHARGE_TIME, 5);
        pc = $urandom & 8'he3;
        apb(1, `IDX_PRECHARGE_CTRL, pc);
        apb(0, `IDX_PRECHARGE_CTRL, 0);
        check(rd, pc);
        for (int i = 0; i < 2; i++) begin
            inv = i[0] & pc[6] & pc[0];
            {g, p} = {pc[5] ^ inv, pc[7] ^ inv};
            fork
                u_seq_model.convert($urandom, i[0], 0);
                begin
                    repeat (3) @(posedge CLK);
                    check({ga, gb, pe, hh}, {g, g, ~pc[1], ~p});
                    if (!pc[1]) check(ph, p);
                    repeat (3) @(posedge CLK);
                    check({ga, gb, pe}, {~g, g, 1'b0});
                end
            join
        end
        $display("test guard done");
        // error selection in basic single-sample mode
        apb(1, `IDX_PRECHARGE_CTRL, 0);
        spt = $urandom % 1024;
        apb(1, `IDX_SETPOINT, spt);
        for (int j = 0; j < 8; j++) begin
            a = $urandom;
            b = $urandom;
            apb(1, `IDX_ERROR_CTRL, {codes[j], 4'h0});
            u_seq_model.convert(a, 0, 0);
            u_seq_model.convert(b, 0, $urandom % 3);
            apb(0, `IDX_ERROR_VALUE, 0);
            check(rd[15:0], err_exp(codes[j], a, b, spt));
            apb(0, `IDX_PREVIOUS_VALUE, 0);
            check(rd, a);
        end
        $display("test error done");
        // shift kept within the legal codes
        s = 1 + $urandom % 3;
        // sample count two to the shift
        n = 1 << s;
        v = $urandom | 1;
        m = 1 + $urandom % 3;
        // a first sum, so that the clear has something to remove; previous follows the filter
        apb(1, `IDX_COMPUTE_CTRL, {1'b1, s[2:0], 1'b0, m[2:0]});
        u_seq_model.convert(v, 0, 0);
        apb(1, `IDX_COMPUTE_CTRL, {1'b1, s[2:0], 1'b1, m[2:0]});
        rd = 32'hffffffff;
        for (int t = 0; t < 20 && rd[3] !== 1'b0; t++) apb(0, `IDX_COMPUTE_CTRL, 0);
        check(rd[3], 0);
        apb(0, `IDX_ACCUMULATOR, 0);
        check(rd, 0);
        repeat (n) u_seq_model.convert(v, 0, $urandom % 3);
        apb(0, `IDX_ACCUMULATOR, 0);
        check(rd, n * v);
        apb(0, `IDX_FILTER_OUTPUT, 0);
        check(rd, v);
        apb(0, `IDX_PREVIOUS_VALUE, 0);
        check(rd, ((n - 1) * v) >> s);
        $display("test accumulate done");
        // double sample: first half stores, second computes; reserved code left error at zero
        apb(1, `IDX_PRECHARGE_CTRL, 1);
        apb(1, `IDX_COMPUTE_CTRL, 0);
        apb(1, `IDX_ERROR_CTRL, 8'h10);
        a = $urandom;
        b = $urandom;
        u_seq_model.convert(a, 0, 0);
        apb(0, `IDX_ERROR_VALUE, 0);
        check(rd, 0);
        u_seq_model.convert(b, 1, 0);
        apb(0, `IDX_ERROR_VALUE, 0);
        check(rd[15:0], 16'(b - a - spt));
        $display("test double done");
        // masked, unmasked, then cleared interrupt
        check(IRQ, 0);
        apb(1, `IDX_IRQ_MASK, 1);
        repeat (2) @(posedge CLK);
        check(IRQ, 1);
        apb(1, `IDX_IRQ_STATUS, 7);
        repeat (2) @(posedge CLK);
        check(IRQ, 0);
        $display("test interrupt done");
        print_verdict();
    end
endmodule

`default_nettype wire
